/* File: tcs_pkg.sv */
// Constants, register map and types for the trip circuit supervision block
`default_nettype none
package tcs_pkg;
    // Clock and scan timing
    localparam int unsigned CLK_FREQ_HZ = 250_000_000;
    localparam int unsigned MS_PER_SEC = 1000;
    localparam int unsigned SCAN_PERIOD_MS = 500;
    localparam int unsigned SCAN_CYCLES = (CLK_FREQ_HZ / MS_PER_SEC) * SCAN_PERIOD_MS;
    localparam int unsigned TICKS_PER_SEC = MS_PER_SEC / SCAN_PERIOD_MS;
    localparam int unsigned TWO_INPUT_SAMPLES = 3;

    // Circuits and delay counting
    localparam int unsigned MAX_CIRCUITS = 3;
    localparam int unsigned CNT_W = 7;
    localparam logic [4:0] DELAY_MIN_S = 5'h01;
    localparam logic [4:0] DELAY_MAX_S = 5'h1E;
    localparam logic [CNT_W-1:0] TWO_INPUT_THR = CNT_W'(TWO_INPUT_SAMPLES);
    localparam logic [CNT_W-1:0] TICKS_PER_SEC_C = CNT_W'(TICKS_PER_SEC);

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ROUTE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_TWO_BIT = 1;
    localparam int unsigned CTRL_CNT_LSB = 2;
    localparam int unsigned CTRL_DLY_LSB = 4;

    // Control reset values
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_TWO_INPUT = 1'b1;
    localparam logic [1:0] RST_CIRCUITS = 2'h3;
    localparam logic [4:0] RST_DELAY_S = 5'h02;
    localparam logic [5:0] RST_ROUTE = 6'h00;

    // Interrupt status layout: bits 2..0 circuit alarm, bit 3 routing fault
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_ROUTE_BIT = 3;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_OK = 3'b010,
        ST_ALARM = 3'b100
    } sup_state_e;
endpackage
`default_nettype wire

/* File: trip_circuit_supervision.sv */
// Trip circuit supervision with AHB-Lite register slave and interrupt
`default_nettype none

// Functional notes
// - Flag each circuit whose routed inputs do not suit the selected mode.
// - Each breaker pole circuit gets its own independent supervision instance.
// - Two-input mode: both inputs low is abnormal, other combinations normal.
// - Two-input mode samples both inputs on a 500 ms scan tick.
// - Two-input alarm only after three consecutive abnormal samples.
// - Alarm clears automatically after the same delay once condition disappears.
// - One-input mode: input low only while trip contact closed; brief low ignored.
// - One-input mode: low longer than alarm delay raises the failure alarm.
// - One-input alarm delay settable 1 to 30 seconds, default 2.
// - Two-input delay fixed by scan and repeat count, not settable.
// - Supervision suspended while a system fault is in progress.
// - On/off enable setting, default off.
// - Status output asserted while supervision is switched off.
// - Inputs per circuit selectable one or two, default two.
// - Three circuits; per-circuit routing fault output blocks that circuit.
// - One common failure output, high when any circuit is alarmed.
// - Circuit count is a setting; zero removes supervision entirely.
module trip_circuit_supervision
    import tcs_pkg::*;
#(
    parameter int unsigned SCAN_TICK_CYCLES = tcs_pkg::SCAN_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Contact sense inputs, one bit per circuit
    input wire logic [tcs_pkg::MAX_CIRCUITS-1:0] trip_relay_sense_in,
    input wire logic [tcs_pkg::MAX_CIRCUITS-1:0] breaker_contact_sense_in,
    input wire logic system_fault_in,
    // Status outputs
    output logic circuit_failure_out,
    output logic supervision_off_status,
    output logic [tcs_pkg::MAX_CIRCUITS-1:0] circuit_routing_fault,
    output logic routing_fault_alarm,
    output logic irq
);
    import tcs_pkg::*;

    localparam int unsigned N = MAX_CIRCUITS;

    // Settings
    logic supervision_enable_r;
    logic inputs_per_circuit_r;
    logic [1:0] supervised_circuit_count_r;
    logic [4:0] alarm_delay_r;
    logic [5:0] route_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;

    // Bus data phase
    logic wr_pend_r;
    logic [7:0] addr_r;

    // Scan tick
    logic [31:0] tick_cnt_r;
    logic tick_r;

    // Per-circuit state
    logic [N-1:0] alarm_w;
    logic [N-1:0] alarm_d_r;
    logic [N-1:0] route_fault_w;
    logic route_any_d_r;

    // Bus decode
    wire addr_take = hsel && htrans[1] && hready;
    wire rd_take = addr_take && !hwrite;
    wire wr_ctrl = wr_pend_r && (addr_r == ADDR_CTRL);
    wire wr_route = wr_pend_r && (addr_r == ADDR_ROUTE);
    wire wr_istat = wr_pend_r && (addr_r == ADDR_IRQ_STAT);
    wire wr_imask = wr_pend_r && (addr_r == ADDR_IRQ_MASK);
    wire [7:0] rd_addr = haddr[7:0];

    // Read views
    wire [31:0] ctrl_view = {23'h000000, alarm_delay_r, supervised_circuit_count_r,
                             inputs_per_circuit_r, supervision_enable_r};
    wire [31:0] status_view = {18'h00000, breaker_contact_sense_in, trip_relay_sense_in,
                               circuit_failure_out, supervision_off_status,
                               route_fault_w, alarm_w};
    wire [31:0] rd_mux = (rd_addr == ADDR_CTRL) ? ctrl_view :
                         (rd_addr == ADDR_ROUTE) ? {26'h0000000, route_r} :
                         (rd_addr == ADDR_STATUS) ? status_view :
                         (rd_addr == ADDR_IRQ_STAT) ? {28'h0000000, irq_stat_r} :
                         (rd_addr == ADDR_IRQ_MASK) ? {28'h0000000, irq_mask_r} :
                         32'h00000000;

    wire [4:0] delay_eff = (alarm_delay_r < DELAY_MIN_S) ? DELAY_MIN_S :
                           (alarm_delay_r > DELAY_MAX_S) ? DELAY_MAX_S : alarm_delay_r;
    wire [CNT_W-1:0] one_input_thr = CNT_W'({2'b00, delay_eff} * TICKS_PER_SEC_C);
    wire [CNT_W-1:0] thr = inputs_per_circuit_r ? TWO_INPUT_THR : one_input_thr;

    // Interrupt events
    wire route_any = |route_fault_w;
    wire [IRQ_W-1:0] irq_evt = {route_any && !route_any_d_r, alarm_w & ~alarm_d_r};
    wire [IRQ_W-1:0] irq_clr = wr_istat ? hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
    // Set wins over write-one clear
    wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

    // Bus slave, always zero wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            wr_pend_r <= addr_take && hwrite;
            addr_r <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_take) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Setting registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supervision_enable_r <= RST_ENABLE;
            inputs_per_circuit_r <= RST_TWO_INPUT;
            supervised_circuit_count_r <= RST_CIRCUITS;
            alarm_delay_r <= RST_DELAY_S;
            route_r <= RST_ROUTE;
            irq_mask_r <= {IRQ_W{1'b0}};
        end else begin
            if (wr_ctrl) begin
                supervision_enable_r <= hwdata[CTRL_EN_BIT];
                inputs_per_circuit_r <= hwdata[CTRL_TWO_BIT];
                supervised_circuit_count_r <= hwdata[CTRL_CNT_LSB +: 2];
                alarm_delay_r <= hwdata[CTRL_DLY_LSB +: 5];
            end
            if (wr_route) begin
                route_r <= hwdata[5:0];
            end
            if (wr_imask) begin
                irq_mask_r <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // Interrupt status and output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= {IRQ_W{1'b0}};
            alarm_d_r <= {N{1'b0}};
            route_any_d_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            alarm_d_r <= alarm_w;
            route_any_d_r <= route_any;
            irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= SCAN_TICK_CYCLES - 1) begin
            tick_cnt_r <= 32'h00000000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
            tick_r <= 1'b0;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_circ
            // circuit present only below the count
            wire present = (2'(i) < supervised_circuit_count_r);
            wire trip_routed = route_r[i];
            wire bkr_routed = route_r[N + i];
            assign route_fault_w[i] = present &&
                (inputs_per_circuit_r ? !(trip_routed && bkr_routed) : !trip_routed);
            wire active = present && supervision_enable_r && !route_fault_w[i];
            wire both_low = !trip_relay_sense_in[i] && !breaker_contact_sense_in[i];
            wire trip_low = !trip_relay_sense_in[i];
            wire abnormal = inputs_per_circuit_r ? both_low : trip_low;

            circuit_monitor #(
                .CW(CNT_W)
            ) i_mon (
                .hclk(hclk),
                .hresetn(hresetn),
                .tick(tick_r),
                .active(active),
                .hold(system_fault_in),
                .abnormal(abnormal),
                .thr(thr),
                .alarm(alarm_w[i])
            );
        end
    endgenerate

    // Registered status outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            circuit_failure_out <= 1'b0;
            supervision_off_status <= 1'b1;
            circuit_routing_fault <= {N{1'b0}};
            routing_fault_alarm <= 1'b0;
        end else begin
            circuit_failure_out <= |alarm_w;
            supervision_off_status <= !supervision_enable_r;
            circuit_routing_fault <= route_fault_w;
            routing_fault_alarm <= route_any;
        end
    end

    wire unused_ok = &{1'b0, hsize, haddr[31:8]};
endmodule

// One supervised circuit: sample counter and alarm state
module circuit_monitor
    import tcs_pkg::*;
#(
    parameter int unsigned CW = tcs_pkg::CNT_W
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Scan and qualification
    input wire logic tick,
    input wire logic active,
    input wire logic hold,
    // Sample and threshold
    input wire logic abnormal,
    input wire logic [CW-1:0] thr,
    // Alarm state
    output logic alarm
);
    import tcs_pkg::*;

    sup_state_e state_r;
    sup_state_e state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    wire [CW-1:0] cnt_inc = cnt_r + CW'(1);

    assign alarm = (state_r == ST_ALARM);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (!active) begin
            state_nxt = ST_OFF;
            cnt_nxt = {CW{1'b0}};
        end else if (hold) begin
            cnt_nxt = {CW{1'b0}};
            if (state_r == ST_OFF) begin
                state_nxt = ST_OK;
            end
        end else begin
            case (state_r)
                ST_OFF: begin
                    state_nxt = ST_OK;
                    cnt_nxt = {CW{1'b0}};
                end
                ST_OK: begin
                    if (tick) begin
                        if (abnormal && cnt_inc >= thr) begin
                            state_nxt = ST_ALARM;
                            cnt_nxt = {CW{1'b0}};
                        end else if (abnormal) begin
                            cnt_nxt = cnt_inc;
                        end else begin
                            cnt_nxt = {CW{1'b0}};
                        end
                    end
                end
                ST_ALARM: begin
                    if (tick) begin
                        if (!abnormal && cnt_inc >= thr) begin
                            state_nxt = ST_OK;
                            cnt_nxt = {CW{1'b0}};
                        end else if (!abnormal) begin
                            cnt_nxt = cnt_inc;
                        end else begin
                            cnt_nxt = {CW{1'b0}};
                        end
                    end
                end
                default: begin
                    state_nxt = ST_OFF;
                    cnt_nxt = {CW{1'b0}};
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_OFF;
            cnt_r <= {CW{1'b0}};
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: tcs_checker.sv */
// Assertion checker for the trip circuit supervision block
`default_nettype none
module tcs_checker
    import tcs_pkg::*;
#(
    parameter int unsigned SCAN_TICK_CYCLES = 8
) (
    // Clock and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // Supervision
    input wire logic [tcs_pkg::MAX_CIRCUITS-1:0] trip_relay_sense_in,
    input wire logic system_fault_in,
    input wire logic circuit_failure_out,
    input wire logic supervision_off_status,
    input wire logic [tcs_pkg::MAX_CIRCUITS-1:0] circuit_routing_fault,
    input wire logic routing_fault_alarm,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // Depth of the scan sample taken one tick before the alarming one
    localparam int LOOK = SCAN_TICK_CYCLES + 2;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_ready; $past(hresetn) |-> hreadyout; endproperty
    property p_okay; hresp == 1'h0; endproperty
    property p_unmapped;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h10 |=> hrdata == 32'h0;
    endproperty
    property p_route_or; $rose(|circuit_routing_fault) |-> ##[0:1] routing_fault_alarm; endproperty
    property p_route_clear; !(|circuit_routing_fault) [*2] |-> !routing_fault_alarm; endproperty
    property p_fault_hold; system_fault_in [*4] |-> $stable(circuit_failure_out); endproperty
    property p_off_quiet; supervision_off_status [*3] |-> !circuit_failure_out; endproperty
    property p_rise_cause;
        $rose(circuit_failure_out) |->
            |(~$past(trip_relay_sense_in, 2) & ~$past(trip_relay_sense_in, LOOK));
    endproperty
    a_ready: assert property (p_ready) else $error("bus not ready");
    a_okay: assert property (p_okay) else $error("bus error response");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_route_or: assert property (p_route_or) else $error("routing alarm missing");
    a_route_clear: assert property (p_route_clear) else $error("routing alarm stuck");
    a_fault_hold: assert property (p_fault_hold) else $error("alarm moved in fault");
    a_off_quiet: assert property (p_off_quiet) else $error("alarm while off");
    a_rise_cause: assert property (p_rise_cause) else $error("alarm too early");
    c_alarm: cover property ($rose(circuit_failure_out));
    c_clear: cover property ($fell(circuit_failure_out));
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: contact_model.sv */
// Trip contact and breaker contact model feeding the sense inputs
`default_nettype none
module contact_model
    import tcs_pkg::*;
(
    // Contact states
    input wire logic [tcs_pkg::MAX_CIRCUITS-1:0] trip_closed,
    input wire logic [tcs_pkg::MAX_CIRCUITS-1:0] breaker_off,
    // Binary input levels
    output logic [tcs_pkg::MAX_CIRCUITS-1:0] trip_relay_sense_in,
    output logic [tcs_pkg::MAX_CIRCUITS-1:0] breaker_contact_sense_in
);
    timeunit 1ns;
    timeprecision 100ps;
    assign trip_relay_sense_in = ~trip_closed;
    assign breaker_contact_sense_in = breaker_off;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the trip circuit supervision block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tcs_pkg::*;
    localparam int unsigned TICK = 8;
    typedef struct {
        logic [31:0] ctrl;
        logic [5:0] route;
        logic [2:0] tc;
        logic [2:0] bo;
        int ticks;
        logic fail;
        logic [2:0] rf;
    } row_s;
    row_s rows [12] = '{
        '{32'h2F, 6'h3F, 3'h0, 3'h0, 5, 1'h0, 3'h0}, '{32'h2F, 6'h3F, 3'h0, 3'h7, 5, 1'h0, 3'h0},
        '{32'h2F, 6'h3F, 3'h7, 3'h7, 5, 1'h0, 3'h0}, '{32'h2F, 6'h3F, 3'h2, 3'h0, 5, 1'h1, 3'h0},
        '{32'h2F, 6'h07, 3'h7, 3'h0, 5, 1'h0, 3'h7}, '{32'h2D, 6'h07, 3'h4, 3'h0, 6, 1'h1, 3'h0},
        '{32'h2D, 6'h03, 3'h0, 3'h0, 2, 1'h0, 3'h4}, '{32'h27, 6'h09, 3'h4, 3'h0, 5, 1'h0, 3'h0},
        '{32'h23, 6'h00, 3'h7, 3'h0, 5, 1'h0, 3'h0}, '{32'h1FD, 6'h07, 3'h1, 3'h0, 8, 1'h0, 3'h0},
        '{32'h0D, 6'h07, 3'h1, 3'h0, 4, 1'h1, 3'h0}, '{32'h2E, 6'h3F, 3'h7, 3'h0, 5, 1'h0, 3'h0}
    };
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic sfault = 1'h0;
    logic [2:0] tc = 3'h0;
    logic [2:0] bo = 3'h0;
    logic hready, hreadyout, hresp, fail_out, off_st, rf_alarm, irq;
    logic [31:0] hrdata, rd;
    logic [2:0] trip_s, brk_s, rf;
    int n_fail = 0;
    int comparisons = 0;
    always #2 hclk = ~hclk;
    assign hready = hreadyout;
    trip_circuit_supervision #(.SCAN_TICK_CYCLES(TICK)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .trip_relay_sense_in(trip_s), .breaker_contact_sense_in(brk_s),
        .system_fault_in(sfault), .circuit_failure_out(fail_out),
        .supervision_off_status(off_st), .circuit_routing_fault(rf),
        .routing_fault_alarm(rf_alarm), .irq(irq)
    );
    contact_model i_contacts (
        .trip_closed(tc), .breaker_off(bo),
        .trip_relay_sense_in(trip_s), .breaker_contact_sense_in(brk_s)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic ticks(input int n);
        repeat (n * TICK) @(posedge hclk);
    endtask
    task automatic close_out;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        foreach (rows[i]) begin
            bus(1'h1, ADDR_CTRL, 32'h0);
            tc <= rows[i].tc;
            bo <= rows[i].bo;
            bus(1'h1, ADDR_ROUTE, 32'(rows[i].route));
            bus(1'h1, ADDR_CTRL, rows[i].ctrl);
            ticks(rows[i].ticks);
            check(fail_out, rows[i].fail);
            check(rf, rows[i].rf);
            check(off_st, !rows[i].ctrl[0]);
            check(rf_alarm, |rows[i].rf);
        end
        hresetn <= 1'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        tc <= 3'h0;
        @(posedge hclk);
        check(off_st, 1'h1);
        bus(1'h0, ADDR_CTRL, 32'h0);
        check(rd, 32'h2E);
        check(rf, 3'h7);
        bus(1'h0, ADDR_IRQ_MASK, 32'h0);
        check(rd, 32'h0);
        bus(1'h0, 8'h20, 32'h0);
        check(rd, 32'h0);
        bus(1'h1, ADDR_ROUTE, 32'h3F);
        bus(1'h1, ADDR_IRQ_MASK, 32'h1);
        bus(1'h1, ADDR_CTRL, 32'h2F);
        ticks(1);
        tc <= 3'h1;
        repeat (10) @(posedge hclk);
        tc <= 3'h0;
        ticks(5);
        check(fail_out, 1'h0);
        tc <= 3'h1;
        ticks(5);
        check(fail_out, 1'h1);
        check(irq, 1'h1);
        bus(1'h0, ADDR_STATUS, 32'h0);
        check(rd, 32'h681);
        tc <= 3'h0;
        ticks(1);
        check(fail_out, 1'h1);
        ticks(4);
        check(fail_out, 1'h0);
        bus(1'h0, ADDR_IRQ_STAT, 32'h0);
        check(rd & 32'h1, 32'h1);
        bus(1'h1, ADDR_IRQ_MASK, 32'h0);
        bus(1'h0, ADDR_IRQ_MASK, 32'h0);
        check(irq, 1'h0);
        bus(1'h1, ADDR_IRQ_STAT, 32'hF);
        bus(1'h1, ADDR_IRQ_MASK, 32'hF);
        bus(1'h0, ADDR_IRQ_STAT, 32'h0);
        check(rd, 32'h0);
        check(irq, 1'h0);
        sfault <= 1'h1;
        tc <= 3'h1;
        ticks(6);
        check(fail_out, 1'h0);
        sfault <= 1'h0;
        ticks(5);
        check(fail_out, 1'h1);
        close_out();
    end
endmodule
bind trip_circuit_supervision tcs_checker #(.SCAN_TICK_CYCLES(SCAN_TICK_CYCLES)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .trip_relay_sense_in(trip_relay_sense_in), .system_fault_in(system_fault_in),
    .circuit_failure_out(circuit_failure_out), .supervision_off_status(supervision_off_status),
    .circuit_routing_fault(circuit_routing_fault), .routing_fault_alarm(routing_fault_alarm),
    .irq(irq)
);
`default_nettype wire
